// file: afab_core.sv
// Single-cycle execute stage: add/AND with literal or file, bit clear.
// Assumes the file register read data for instr address is valid
// combinationally in the same cycle, and the file is written on wr.
`timescale 1ns/1ps
`include "afab_regs.svh"
module afab_core (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 instr_valid,
  input  wire logic [13:0]          instr,
  input  wire logic [7:0]           file_rdata,
  output logic [6:0]                file_raddr,
  output afab_pkg::afab_fwr_t       file_wr,
  output logic [7:0]                acc,
  output afab_pkg::afab_flags_t     flags
);
  import afab_pkg::*;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  afab_op_t op;

  afab_decode u_dec (
    .instr (instr),
    .op    (op)
  );

  wire       exec     = instr_valid && (op != AFAB_NONE);
  wire [7:0] lit      = instr[7:0];
  wire [6:0] faddr    = instr[6:0];
  wire       to_file  = instr[7];
  wire [2:0] bit_sel  = instr[9:7];
  wire       lit_op   = (op == AFAB_ADDLIT) || (op == AFAB_ANDLIT);
  wire       add_op   = (op == AFAB_ADDLIT) || (op == AFAB_ADDF);
  wire       and_op   = (op == AFAB_ANDLIT) || (op == AFAB_ANDF);

  assign file_raddr = faddr;

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  wire [7:0] operand  = lit_op ? lit : file_rdata;
  wire [8:0] sum      = {1'b0, acc} + {1'b0, operand};
  wire [4:0] low_sum  = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
  wire [7:0] and_res  = acc & operand;
  wire [7:0] bclr_res = file_rdata & ~(8'h01 << bit_sel);
  wire [7:0] result   = add_op ? sum[7:0] :
                        and_op ? and_res  : bclr_res;

  // Target: literal ops -> acc, bit clear -> file, file ops -> d bit
  wire dest_file = (op == AFAB_BCLR) ||
                   (((op == AFAB_ADDF) || (op == AFAB_ANDF)) &&
                    to_file);
  wire dest_acc  = exec && !dest_file;

  wire       upd_z   = exec && (add_op || and_op);
  wire       upd_cdc = exec && add_op;
  wire       new_z   = (result == 8'h00);

  // Flag bits written by this op override the stored status byte
  wire to_status = dest_file && (faddr == `AFAB_STATUS_ADDR);
  wire [7:0] status_wdata;
  assign status_wdata[7:3] = result[7:3];
  assign status_wdata[`AFAB_FLAG_Z]  = upd_z   ? new_z      :
                                       result[`AFAB_FLAG_Z];
  assign status_wdata[`AFAB_FLAG_DC] = upd_cdc ? low_sum[4] :
                                       result[`AFAB_FLAG_DC];
  assign status_wdata[`AFAB_FLAG_C]  = upd_cdc ? sum[8]     :
                                       result[`AFAB_FLAG_C];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  afab_flags_t flags_d;
  always_comb begin
    flags_d = flags;
    if (exec && to_status) begin
      flags_d.c  = status_wdata[`AFAB_FLAG_C];
      flags_d.dc = status_wdata[`AFAB_FLAG_DC];
      flags_d.z  = status_wdata[`AFAB_FLAG_Z];
    end else begin
      if (upd_z) begin
        flags_d.z = new_z;
      end
      if (upd_cdc) begin
        flags_d.c  = sum[8];
        flags_d.dc = low_sum[4];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc     <= `AFAB_ACC_RESET;
      flags   <= `AFAB_FLAGS_RESET;
      file_wr <= '0;
    end else begin
      if (dest_acc) begin
        acc <= result;
      end
      flags         <= flags_d;
      file_wr.wr_en <= exec && dest_file;
      file_wr.addr  <= faddr;
      file_wr.data  <= to_status ? status_wdata : result;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_addlit;
    instr_valid && op == AFAB_ADDLIT;
  endsequence

  a_addlit_sum: assert property (s_addlit |=>
    acc == 8'($past(acc) + $past(lit)) && flags.c == $past(sum[8]))
    else $error("literal add result wrong");
  a_andlit_acc: assert property (instr_valid && op == AFAB_ANDLIT |=>
    acc == ($past(acc) & $past(lit)) && flags.c == $past(flags.c))
    else $error("literal and result wrong");
  a_addf_flags: assert property (instr_valid && op == AFAB_ADDF &&
    !to_status |=> flags.dc == $past(low_sum[4]) &&
    flags.z == ($past(sum[7:0]) == 8'h00))
    else $error("file add flags wrong");
  a_dest_file: assert property (instr_valid && (op == AFAB_ADDF ||
    op == AFAB_ANDF) && to_file |=> file_wr.wr_en && $stable(acc))
    else $error("file destination not honoured");
  a_dest_acc: assert property (instr_valid && op == AFAB_ANDF &&
    !to_file |=> !file_wr.wr_en &&
    acc == ($past(acc) & $past(file_rdata)))
    else $error("acc destination not honoured");
  a_andf_flags: assert property (instr_valid && op == AFAB_ANDF &&
    !to_status |=> $stable(flags.c) && $stable(flags.dc))
    else $error("file and touched carry");
  a_bclr_write: assert property (instr_valid && op == AFAB_BCLR &&
    !to_status |=> file_wr.wr_en && $stable(acc) && $stable(flags) &&
    file_wr.data == ($past(file_rdata) & ~(8'h01 << $past(bit_sel))))
    else $error("bit clear wrong");
  a_status_dest: assert property (instr_valid && to_status &&
    op == AFAB_ANDF |=> file_wr.data[`AFAB_FLAG_Z] == flags.z)
    else $error("status flag override wrong");
  a_one_cycle: assert property (exec && dest_file |=>
    file_wr.wr_en ##1 !file_wr.wr_en || $past(exec && dest_file, 1))
    else $error("file write not single cycle");

  // ---------------------------------------------------------------
  // Further checks
  // ---------------------------------------------------------------
  sequence s_file_op;
    instr_valid && (op == AFAB_ADDF || op == AFAB_ANDF);
  endsequence

  sequence s_wr_next;
    file_wr.wr_en && file_wr.addr == $past(faddr);
  endsequence

  a_decode_onehot: assert property ($onehot(op))
    else $error("decoded operation not one-hot");

  a_addlit_flags: assert property (
    s_addlit |=> flags.dc == $past(low_sum[4]) &&
    flags.z == ($past(sum[7:0]) == 8'h00))
    else $error("literal add flags wrong");

  a_addlit_nowr: assert property (
    s_addlit |=> !file_wr.wr_en)
    else $error("literal add wrote the file");

  a_andlit_flags: assert property (
    instr_valid && op == AFAB_ANDLIT |=> $stable(flags.dc) &&
    flags.z == ($past(acc & lit) == 8'h00))
    else $error("literal and flags wrong");

  a_addf_acc: assert property (
    instr_valid && op == AFAB_ADDF && !to_file |=>
    acc == 8'($past(acc) + $past(file_rdata)) && !file_wr.wr_en)
    else $error("file add to acc wrong");

  a_addf_wdata: assert property (
    instr_valid && op == AFAB_ADDF && to_file && !to_status |=>
    file_wr.data == 8'($past(acc) + $past(file_rdata)))
    else $error("file add write data wrong");

  a_file_route: assert property (
    s_file_op && to_file |=> s_wr_next)
    else $error("file write address wrong");

  a_andf_wdata: assert property (
    instr_valid && op == AFAB_ANDF && to_file && !to_status |=>
    file_wr.data == ($past(acc) & $past(file_rdata)))
    else $error("file and write data wrong");

  a_andf_zero: assert property (
    instr_valid && op == AFAB_ANDF && !to_status |=>
    flags.z == (($past(acc) & $past(file_rdata)) == 8'h00))
    else $error("file and zero flag wrong");

  a_bclr_others: assert property (
    instr_valid && op == AFAB_BCLR |=>
    (file_wr.data | (8'h01 << $past(bit_sel))) ==
    ($past(file_rdata) | (8'h01 << $past(bit_sel))))
    else $error("bit clear touched other bits");

  a_status_add: assert property (
    instr_valid && to_status && op == AFAB_ADDF |=>
    file_wr.data[`AFAB_FLAG_C] == flags.c &&
    file_wr.data[`AFAB_FLAG_DC] == flags.dc)
    else $error("status add flag override wrong");

  a_status_bclr: assert property (
    instr_valid && to_status && op == AFAB_BCLR |=>
    file_wr.data[`AFAB_FLAG_Z] == flags.z &&
    file_wr.data[`AFAB_FLAG_C] == flags.c)
    else $error("status bit clear not reflected in flags");

  a_refuse_none: assert property (
    instr_valid && op == AFAB_NONE |=>
    !file_wr.wr_en && $stable(acc) && $stable(flags))
    else $error("unknown opcode changed state");

  a_idle_hold: assert property (
    !instr_valid |=> !file_wr.wr_en && $stable(acc) && $stable(flags))
    else $error("state changed without valid instruction");
endmodule

// file: afab_regs.svh
// Constants for the accumulator add / AND / bit-clear execute block.
// Assumes a 14-bit instruction word and a 7-bit file register address space.
`ifndef AFAB_REGS_SVH
`define AFAB_REGS_SVH

`define AFAB_OP_ADDLIT      5'h1f
`define AFAB_OP_ANDLIT      6'h39
`define AFAB_OP_ADDFILE     6'h07
`define AFAB_OP_ANDFILE     6'h05
`define AFAB_OP_BITCLR      4'h4
`define AFAB_STATUS_ADDR    7'h03
`define AFAB_FLAG_C         0
`define AFAB_FLAG_DC        1
`define AFAB_FLAG_Z         2
`define AFAB_ACC_RESET      8'h00
`define AFAB_FLAGS_RESET    3'h0

`endif

// file: afab_pkg.sv
// Types for the accumulator add / AND / bit-clear execute block.
// Uses no afab_regs.svh constants; the one-hot op encodings are defined here.
package afab_pkg;
  typedef enum logic [5:0] {
    AFAB_NONE   = 6'b000001,
    AFAB_ADDLIT = 6'b000010,
    AFAB_ANDLIT = 6'b000100,
    AFAB_ADDF   = 6'b001000,
    AFAB_ANDF   = 6'b010000,
    AFAB_BCLR   = 6'b100000
  } afab_op_t;

  typedef struct packed {
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] data;
  } afab_fwr_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } afab_flags_t;
endpackage

// file: afab_decode.sv
// Instruction decoder for the accumulator add / AND / bit-clear block.
// Assumes a 14-bit instruction word valid in the current cycle.
`timescale 1ns/1ps
`include "afab_regs.svh"
module afab_decode (
  input  wire logic [13:0]       instr,
  output afab_pkg::afab_op_t     op
);
  import afab_pkg::*;

  wire is_addlit = (instr[13:9] == `AFAB_OP_ADDLIT);
  wire is_andlit = (instr[13:8] == `AFAB_OP_ANDLIT);
  wire is_addf   = (instr[13:8] == `AFAB_OP_ADDFILE);
  wire is_andf   = (instr[13:8] == `AFAB_OP_ANDFILE);
  wire is_bclr   = (instr[13:10] == `AFAB_OP_BITCLR);

  assign op = is_addlit ? AFAB_ADDLIT :
              is_andlit ? AFAB_ANDLIT :
              is_addf   ? AFAB_ADDF   :
              is_andf   ? AFAB_ANDF   :
              is_bclr   ? AFAB_BCLR   :
                          AFAB_NONE;
endmodule

// file: afab_tb.sv
// Self-checking testbench for the add / AND / bit-clear execute block.
// Assumes afab_pkg is compiled first; the bench plays the file register.
`timescale 1ns/1ps
module testbench;
  import afab_pkg::*;

  // ----------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------
  logic        clk;
  logic        rstn;
  logic        instr_valid;
  logic [13:0] instr;
  logic [7:0]  file_rdata;
  logic [6:0]  file_raddr;
  afab_fwr_t   file_wr;
  logic [7:0]  acc;
  afab_flags_t flags;
  int          n_fail;
  int          compares;

  afab_core u_afab_core (
    .clk        (clk),
    .rstn       (rstn),
    .instr_valid(instr_valid),
    .instr      (instr),
    .file_rdata (file_rdata),
    .file_raddr (file_raddr),
    .file_wr    (file_wr),
    .acc        (acc),
    .flags      (flags)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Compare and drive tasks
  // ----------------------------------------
  task automatic fail(input string msg);
    n_fail++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
  endtask

  task automatic chk_flags(input afab_flags_t got, input logic [2:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("flags %b, expected %b", got, exp));
  endtask

  task automatic chk_wr(input logic en, input logic [6:0] a,
                        input logic [7:0] d);
    compares++;
    if (en === 1'b0 && file_wr.wr_en !== 1'b0) fail("unexpected write");
    if (en === 1'b1 && file_wr !== {en, a, d}) fail("file write wrong");
  endtask

  // Present one word for one cycle; returns just after it has executed
  task automatic run(input logic v, input logic [13:0] i,
                     input logic [7:0] rd);
    @(posedge clk);
    instr       <= i;
    file_rdata  <= rd;
    instr_valid <= v;
    #1 chk_byte({1'b0, file_raddr}, {1'b0, i[6:0]});
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_sum_lit();
    run(1'b1, 14'h3e10, 8'h00);
    run(1'b1, 14'h3e15, 8'h00);
    chk_byte(acc, 8'h25); chk_flags(flags, 3'h0);
    run(1'b1, 14'h3fff, 8'h00);
    chk_byte(acc, 8'h24); chk_flags(flags, 3'h6);
    run(1'b1, 14'h3fdc, 8'h00);
    chk_byte(acc, 8'h00); chk_flags(flags, 3'h7);
  endtask

  task automatic t_mask_lit();
    run(1'b1, 14'h3ea3, 8'h00);
    run(1'b1, 14'h3f60, 8'h00);
    run(1'b1, 14'h395f, 8'h00);
    chk_byte(acc, 8'h03); chk_flags(flags, 3'h4);
    run(1'b1, 14'h3900, 8'h00);
    chk_byte(acc, 8'h00); chk_flags(flags, 3'h5);
  endtask

  task automatic t_file_ops();
    run(1'b1, 14'h3e17, 8'h00);
    run(1'b1, 14'h0725, 8'hc2);
    chk_byte(acc, 8'hd9); chk_wr(1'b0, 7'h00, 8'h00);
    run(1'b1, 14'h07a5, 8'h27);
    chk_wr(1'b1, 7'h25, 8'h00); chk_flags(flags, 3'h7);
    run(1'b1, 14'h0590, 8'hc2);
    chk_wr(1'b1, 7'h10, 8'hc0); chk_byte(acc, 8'hd9);
    chk_flags(flags, 3'h6);
    run(1'b1, 14'h0510, 8'h26);
    chk_byte(acc, 8'h00); chk_flags(flags, 3'h7);
  endtask

  task automatic t_bit_clr();
    for (int b = 0; b < 8; b++) begin
      run(1'b1, {4'h4, 3'(b), 7'h31}, 8'hc7);
      chk_wr(1'b1, 7'h31, 8'hc7 & ~(8'h01 << b));
      chk_flags(flags, 3'h7); chk_byte(acc, 8'h00);
    end
  endtask

  task automatic t_status();
    run(1'b1, 14'h0783, 8'h00);
    chk_wr(1'b1, 7'h03, 8'h04); chk_flags(flags, 3'h1);
    run(1'b1, {4'h4, 3'h0, 7'h03}, 8'h07);
    chk_wr(1'b1, 7'h03, 8'h06); chk_flags(flags, 3'h3);
  endtask

  task automatic t_refuse_b2b();
    run(1'b1, 14'h3800, 8'hff);
    run(1'b0, 14'h3e01, 8'h00);
    chk_byte(acc, 8'h00); chk_wr(1'b0, 7'h00, 8'h00);
    @(posedge clk);
    instr       <= 14'h3e01;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr <= 14'h3eff;
    #1 chk_byte(acc, 8'h01);
    @(posedge clk);
    instr_valid <= 1'b0;
    #1 chk_byte(acc, 8'h00); chk_flags(flags, 3'h7);
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial begin
    n_fail = 0;
    compares = 0;
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr = 14'h0000;
    file_rdata = 8'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_sum_lit();
    t_mask_lit();
    t_file_ops();
    t_bit_clr();
    t_status();
    t_refuse_b2b();
    stop_test();
  end

  initial begin
    #50000;
    fail("run did not finish");
    stop_test();
  end
endmodule
